// >>> rtl/pmc_regs.svh
// Register offsets, fields and timing counts for the power mode control block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_ADDR_POWER_MODE_CONTROL 8'h87
`define PMC_RESET_POWER_MODE_CONTROL 8'h00
`define PMC_BIT_HALT 0
`define PMC_BIT_DEEP 1
`define PMC_MCD_TIMEOUT_NS 100000
`define PMC_CLK_PERIOD_NS 10
`define PMC_MCD_CYCLES (`PMC_MCD_TIMEOUT_NS / `PMC_CLK_PERIOD_NS)
`endif

// >>> rtl/pmc_pkg.sv
// Types shared by the power mode control block
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_RUN   = 3'h1,
		PMC_LIGHT = 3'h2,
		PMC_DEEP  = 3'h4
	} pmc_state_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmc_sfr_req_t;
endpackage

// >>> rtl/pmc_sync.sv
// Two-flop synchroniser for asynchronous wake and reset-source inputs
`timescale 1ns/10ps
`default_nettype none
module pmc_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/pmc_top.sv
// Power mode control: halt and deep sleep sequencing for the CPU core
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire pmc_sfr_req_t  sfr_req,
	input  wire logic          instr_done,
	input  wire logic          irq_pending,
	input  wire logic          wdt_timeout,
	input  wire logic          mcd_enable,
	input  wire logic          ext_reset_req,
	output logic [7:0]         sfr_rdata,
	output logic               cpu_clk_en,
	output logic               periph_clk_en,
	output logic               int_osc_en,
	output logic               irq_en,
	output logic               sys_reset_req,
	output logic               in_light_sleep,
	output logic               in_deep_sleep
);
	pmc_state_t  state_r;
	pmc_state_t  state_nxt;
	logic        halt_r;
	logic        pend_halt_r;
	logic        pend_deep_r;
	logic [13:0] mcd_cnt_r;
	logic        irq_s;
	logic        wdt_s;
	logic        ext_s;
	logic        wr_hit;
	logic        any_reset;

	// Wake and reset sources come from other clock regions
	pmc_sync u_irq (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (irq_pending),
		.q     (irq_s)
	);

	pmc_sync u_wdt (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (wdt_timeout),
		.q     (wdt_s)
	);

	pmc_sync u_ext (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (ext_reset_req),
		.q     (ext_s)
	);

	assign wr_hit = sfr_req.wr && (sfr_req.addr == `PMC_ADDR_POWER_MODE_CONTROL);
	assign any_reset = wdt_s || ext_s ||
		(mcd_enable && (mcd_cnt_r == 14'(`PMC_MCD_CYCLES - 1)));

	// Sleep requests wait for the writing instruction to retire
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_halt_r <= 1'b0;
			pend_deep_r <= 1'b0;
		end else if (wr_hit) begin
			pend_deep_r <= sfr_req.wdata[`PMC_BIT_DEEP];
			pend_halt_r <= sfr_req.wdata[`PMC_BIT_HALT] && !sfr_req.wdata[`PMC_BIT_DEEP];
		end else if (instr_done) begin
			pend_halt_r <= 1'b0;
			pend_deep_r <= 1'b0;
		end
	end

	// Halt select bit, readable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_r <= 1'b0;
		end else if (state_r == PMC_LIGHT && (irq_s || any_reset)) begin
			halt_r <= 1'b0;
		end else if (wr_hit) begin
			halt_r <= sfr_req.wdata[`PMC_BIT_HALT] && !sfr_req.wdata[`PMC_BIT_DEEP];
		end
	end

	// stall only, no jump
	// The core keeps its program counter while gated, so the interrupt
	// return lands on the instruction after the halting write.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PMC_RUN: begin
				if (instr_done && pend_deep_r) begin
					state_nxt = PMC_DEEP;
				end else if (instr_done && pend_halt_r) begin
					state_nxt = PMC_LIGHT;
				end
			end
			PMC_LIGHT: begin
				if (irq_s || any_reset) begin
					state_nxt = PMC_RUN;
				end
			end
			PMC_DEEP: begin
				if (any_reset) begin
					state_nxt = PMC_RUN;
				end
			end
			default: state_nxt = PMC_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PMC_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// detector counts while deep sleep stops the clock source
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mcd_cnt_r <= 14'h0;
		end else if (state_r == PMC_DEEP && mcd_enable) begin
			mcd_cnt_r <= mcd_cnt_r + 14'h1;
		end else begin
			mcd_cnt_r <= 14'h0;
		end
	end

	// only CPU clock gated in light sleep; deep sleep also gates periph, oscillator and irq enables
	// Outputs lag the state by one cycle so every pin leaves a flop.
	// light sleep gates CPU only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_clk_en <= 1'b1;
		end else begin
			cpu_clk_en <= (state_r == PMC_RUN);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_clk_en <= 1'b1;
		end else begin
			periph_clk_en <= (state_r != PMC_DEEP);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_osc_en <= 1'b1;
		end else begin
			int_osc_en <= (state_r != PMC_DEEP);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en <= 1'b1;
		end else begin
			irq_en <= (state_r != PMC_DEEP);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= any_reset;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_light_sleep <= 1'b0;
		end else begin
			in_light_sleep <= (state_r == PMC_LIGHT);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_deep_sleep <= 1'b0;
		end else begin
			in_deep_sleep <= (state_r == PMC_DEEP);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= `PMC_RESET_POWER_MODE_CONTROL;
		end else if (sfr_req.rd && sfr_req.addr == `PMC_ADDR_POWER_MODE_CONTROL) begin
			sfr_rdata <= {7'h00, halt_r};
		end else begin
			sfr_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// >>> verif/pmc_top_assertions.sv
// Port checks for the power mode block
`timescale 1ns/10ps
`default_nettype none
module pmc_top_assertions
	import pmc_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst_n,
	input wire pmc_sfr_req_t sfr_req,
	input wire logic         instr_done,
	input wire logic         irq_pending,
	input wire logic [7:0]   sfr_rdata,
	input wire logic         cpu_clk_en,
	input wire logic         periph_clk_en,
	input wire logic         int_osc_en,
	input wire logic         irq_en,
	input wire logic         sys_reset_req,
	input wire logic         in_light_sleep,
	input wire logic         in_deep_sleep
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	light_gate_a: assert property (in_light_sleep && $past(in_light_sleep) |->
		!cpu_clk_en && periph_clk_en && int_osc_en && irq_en) else $error("light gate");
	deep_stop_a: assert property (in_deep_sleep && $past(in_deep_sleep) |->
		!(cpu_clk_en | periph_clk_en | int_osc_en | irq_en)) else $error("deep gate");
	deep_hold_a: assert property ($fell(in_deep_sleep) |-> $past(sys_reset_req))
		else $error("deep left");
	rd_zero_a: assert property (sfr_rdata[7:1] == 7'h00) else $error("rdata bits");
	unmapped_rd_a: assert property ($past(sfr_req.rd && sfr_req.addr != 8'h87) |->
		sfr_rdata == 8'h00) else $error("unmapped read");
	sleep_entry_a: assert property ($rose(in_light_sleep || in_deep_sleep) |->
		$past(instr_done, 2) || $past(instr_done, 3)) else $error("early sleep");
	irq_wake_a: assert property (in_light_sleep && irq_pending |->
		##[1:6] !in_light_sleep) else $error("no wake");
	one_mode_a: assert property (!(in_light_sleep && in_deep_sleep)) else $error("two modes");
endmodule
bind pmc_top pmc_top_assertions u_pmc_top_assertions (.*);
`default_nettype wire

// >>> verif/pmc_cpu_model.sv
// Core model: retires the writing instruction some cycles later
`timescale 1ns/10ps
`default_nettype none
module pmc_cpu_model (
	input  wire logic       clk,
	input  wire logic       wr,
	input  wire logic [1:0] lag,
	input  wire logic       fire,
	output logic            instr_done,
	output logic            wdt_timeout
);
	int n = 0;
	// watchdog disabled unless the bench fires it
	assign wdt_timeout = fire;
	assign instr_done = (n == 1);
	always @(posedge clk) begin
		n <= wr ? lag + 2 : (n > 0 ? n - 1 : 0);
	end
endmodule
`default_nettype wire

// >>> verif/test_cpu_power_mode_control.sv
// Bench for the power mode block
`timescale 1ns/10ps
`default_nettype none
module test_cpu_power_mode_control;
	import pmc_pkg::*;
	logic clk = 0, rst_n = 0, irq = 0, ext = 0;
	pmc_sfr_req_t req = '0;
	logic [7:0] rdat, dat[3] = '{8'h01, 8'h03, 8'h02}, a;
	logic cpu_en, per_en, osc_en, iq_en, srst, lt, dp, done, wdt;
	logic [1:0] lag = 0;
	logic wfire = 0, missing_clock_detector = 0;
	logic [3:0] ex[3] = '{4'h3, 4'h9, 4'h4};
	int fails = 0, comparisons = 0, seed = 72497, mode = 0;
	pmc_top u_pmc_top (.clk, .rst_n, .sfr_req(req), .instr_done(done), .irq_pending(irq),
		.wdt_timeout(wdt), .mcd_enable(missing_clock_detector), .ext_reset_req(ext), .sfr_rdata(rdat),
		.cpu_clk_en(cpu_en), .periph_clk_en(per_en), .int_osc_en(osc_en), .irq_en(iq_en),
		.sys_reset_req(srst), .in_light_sleep(lt), .in_deep_sleep(dp));
	pmc_cpu_model u_pmc_cpu_model (.clk, .wr(req.wr), .lag, .fire(wfire), .instr_done(done),
		.wdt_timeout(wdt));
	task chk(logic [7:0] g, logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task acc(logic w, logic [7:0] ad, logic [7:0] d);
		req = {w, ~w, ad, d};
		cyc(1);
		req = '0;
	endtask
	task st;
		chk({lt, dp, cpu_en, osc_en}, ex[mode]);
	endtask
	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#150000;
		fails++;
		give_verdict;
	end
	initial begin
		cyc(2);
		rst_n = 1;
		cyc(1);
		acc(0, 8'h87, 0);
		chk(rdat, 8'h00);
		for (int i = 0; i < 3; i++) begin
			lag = $random(seed);
			a = $random(seed) | 8'h10;
			acc(0, a, 0);
			chk(rdat, 8'h00);
			acc(1, 8'h87, dat[i]);
			mode = dat[i][1] ? 2 : 1;
			cyc(8);
			st();
			acc(0, 8'h87, 0);
			chk(rdat, {7'h0, mode == 1});
			irq = 1;
			cyc(6);
			if (mode == 1) mode = 0;
			st();
			irq = 0;
			ext = (i != 1);
			wfire = (i == 1);
			cyc(5);
			chk(srst, 1);
			rst_n = 0;
			cyc(1);
			rst_n = 1;
			ext = 0;
			wfire = 0;
			mode = 0;
			cyc(1);
			st();
			$display("test %0d done", i);
		end
		acc(1, 8'h87, 8'h02);
		mode = 2;
		cyc(8);
		missing_clock_detector = 1;
		cyc(9990);
		st();
		cyc(20);
		mode = 0;
		st();
		$display("test mcd done");
		give_verdict;
	end
endmodule
`default_nettype wire
